// ==== pkg/fbwm_defs.vh ====
/*
  Constants for the framebuffer write-mask and clear stage: command codes,
  error codes, targets, face selectors, reset values and field positions.
  Assumes inclusion by bare name from the design files under hw/.
*/
// Function
// (R1) Four colour enables per draw buffer gate each component write.
// (R2) A selector naming several buffers applies its mask to each of them.
// (R3) Global mask command loads every buffer; indexed form loads one buffer.
// (R4) Indexed mask index beyond count minus one flags invalid value, no change.
// (R5) Reset enables every colour component and sets depth write enable.
// (R6) Non-zero argument sets depth enable, zero clears; cleared blocks depth writes.
// (R7) Low stencil mask bits gate stencil bits: 1 writes, 0 preserves.
// (R8) Front mask for front-facing fragments, back mask for back-facing ones.
// (R9) Face command updates front, back or both; plain command loads both.
// (R10) Stencil clear always uses the front stencil mask.
// (R11) Both stencil masks reset to all ones.
// (R12) With multisample, masks gate sample writes; resolve ignores colour enables.
// (R13) Clear selector has three flags; zero clears nothing; other bits invalid value.
// (R14) Depth clear value is clamped to zero through one.
// (R15) Stencil clear value is truncated to stencil plane count.
// (R16) Clears skip all fragment tests except ownership, scissor, dither and masks.
// (R17) Clear of a missing buffer does nothing and flags no error.
// (R18) Colour clear clamps to 0..1 unsigned-normalized, -1..1 signed-normalized.
// (R19) Reset clear values: colour zero, depth one, stencil zero.
// (R20) Colour clear index out of range, or non-zero depth/stencil index, invalid value.
// (R21) Bad per-buffer clear target, or combined not depth-stencil, invalid enum.
// (R22) Combined clear equals depth clear then stencil clear.
// (R23) A selector of none writes no colour to any buffer.
`ifndef FBWM_DEFS_VH
`define FBWM_DEFS_VH

// Commands
`define FBWM_CMD_ALL_MASK     4'h1
`define FBWM_CMD_IDX_MASK     4'h2
`define FBWM_CMD_DEPTH_EN     4'h3
`define FBWM_CMD_STEN_MASK    4'h4
`define FBWM_CMD_FACE_MASK    4'h5
`define FBWM_CMD_SET_COLOUR   4'h6
`define FBWM_CMD_SET_DEPTH    4'h7
`define FBWM_CMD_SET_STENCIL  4'h8
`define FBWM_CMD_CLEAR        4'h9
`define FBWM_CMD_BUF_CLEAR    4'ha
`define FBWM_CMD_DS_CLEAR     4'hb
`define FBWM_CMD_SET_SEL      4'hc

// Clear selector bits
`define FBWM_CLR_COLOUR       0
`define FBWM_CLR_DEPTH        1
`define FBWM_CLR_STENCIL      2

// Per-buffer clear targets
`define FBWM_TGT_COLOUR       2'h0
`define FBWM_TGT_DEPTH        2'h1
`define FBWM_TGT_STENCIL      2'h2
`define FBWM_TGT_DEPTH_STEN   2'h3

// Face selectors
`define FBWM_FACE_FRONT       2'h1
`define FBWM_FACE_BACK        2'h2
`define FBWM_FACE_BOTH        2'h3

// Error codes
`define FBWM_ERR_NONE         2'h0
`define FBWM_ERR_VALUE        2'h1
`define FBWM_ERR_ENUM         2'h2

// Register read offsets (upper address nibble)
`define FBWM_REG_CMASK        4'h0
`define FBWM_REG_DEPTH_EN     4'h1
`define FBWM_REG_STEN_FRONT   4'h2
`define FBWM_REG_STEN_BACK    4'h3
`define FBWM_REG_CLR_DEPTH    4'h4
`define FBWM_REG_CLR_STENCIL  4'h5
`define FBWM_REG_CLR_COLOUR   4'h6

// Reset values and clamp limits
`define FBWM_RST_CMASK        4'hf
`define FBWM_RST_DEPTH_CLR    32'h3f800000
`define FBWM_FP_ONE           32'h3f800000
`define FBWM_FP_NEG_ONE       32'hbf800000

`endif

// ==== hw/fbwm_clamp.v ====
/*
  Clamps an IEEE single-precision value into [lo,1], where lo is 0 or -1.
  Assumes normal or zero inputs; NaN is treated as its sign suggests.
*/
`timescale 1ns/10ps
`include "fbwm_defs.vh"

module fbwm_clamp
(
  input  wire        signed_range,
  input  wire [31:0] din,
  output reg  [31:0] dout
);

  wire neg      = din[31];
  wire mag_ge_1 = (din[30:0] >= 31'h3f800000);

  always @*
  begin
    if (!neg)
      dout = mag_ge_1 ? `FBWM_FP_ONE : din;
    else if (!signed_range)
      dout = 32'h00000000;
    else
      dout = mag_ge_1 ? `FBWM_FP_NEG_ONE : din;
  end

endmodule

// ==== hw/fbwm_top.v ====
/*
  Framebuffer write-mask and clear stage. Holds colour component enables per
  draw buffer, depth write enable, front/back stencil masks, clear values and
  draw selectors; runs clears and masks fragment writes toward storage.
  Assumes a command front end issuing one-cycle commands, storage accepting
  one write per cycle, and a register port with read data one cycle later.
*/
// The register offsets and the plain strobed port were left to the implementer.
`timescale 1ns/10ps
`include "fbwm_defs.vh"

module fbwm_top
#(
  parameter NBUF     = 4,
  parameter SBITS    = 8,
  parameter IDXW     = 2
)
(
  input  wire               sys_clk,
  input  wire               rstn,
  // Command port
  input  wire               cmd_valid,
  input  wire [3:0]         cmd_code,
  input  wire [31:0]        cmd_index,
  input  wire [1:0]         cmd_arg,
  input  wire [3:0]         cmd_rgba,
  input  wire [31:0]        cmd_data0,
  input  wire [31:0]        cmd_data1,
  input  wire [31:0]        cmd_data2,
  input  wire [31:0]        cmd_data3,
  input  wire               cmd_snorm,
  // Presence of buffers
  input  wire [NBUF-1:0]    colour_present,
  input  wire               depth_present,
  input  wire               stencil_present,
  input  wire               multisample,
  // Fragment port
  input  wire               frag_valid,
  input  wire               frag_back,
  input  wire [NBUF-1:0]    frag_colour_req,
  input  wire               frag_depth_req,
  input  wire               frag_stencil_req,
  input  wire [31:0]        frag_depth,
  input  wire [SBITS-1:0]   frag_stencil,
  // Storage write side
  output reg                wr_valid,
  output reg                wr_sample,
  output reg                wr_is_clear,
  output reg  [4*NBUF-1:0]  wr_colour_en,
  output reg                wr_depth_en,
  output reg  [SBITS-1:0]   wr_stencil_en,
  output reg  [127:0]       wr_colour,
  output reg  [31:0]        wr_depth,
  output reg  [SBITS-1:0]   wr_stencil,
  output reg                resolve_valid,
  output reg  [NBUF-1:0]    resolve_en,
  // Error report
  output reg                err_valid,
  output reg  [1:0]         err_code,
  // Register read port
  input  wire [7:0]         reg_addr,
  input  wire [31:0]        reg_wdata,
  input  wire               reg_wr,
  input  wire               reg_rd,
  output reg  [31:0]        reg_rdata
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  reg  [3:0]       cmask [0:NBUF-1];
  reg  [NBUF-1:0]  sel_map [0:NBUF-1];
  reg              depth_we;
  reg  [SBITS-1:0] sten_front;
  reg  [SBITS-1:0] sten_back;
  reg  [127:0]     clr_colour;
  reg  [31:0]      clr_depth;
  reg  [SBITS-1:0] clr_stencil;

  wire             is_cmd = cmd_valid;
  wire             idx_ok = (cmd_index < NBUF);
  wire [IDXW-1:0]  idx    = cmd_index[IDXW-1:0];

  // ------------------------------------------------------------
  // Clamp units
  // ------------------------------------------------------------
  wire [31:0] cc0;
  wire [31:0] cc1;
  wire [31:0] cc2;
  wire [31:0] cc3;
  wire [31:0] dclamp;
  // Per-buffer clears take the command's colour, global clears the stored one
  wire [31:0] src0 = (cmd_code == `FBWM_CMD_BUF_CLEAR) ? cmd_data0 : clr_colour[31:0];
  wire [31:0] src1 = (cmd_code == `FBWM_CMD_BUF_CLEAR) ? cmd_data1 : clr_colour[63:32];
  wire [31:0] src2 = (cmd_code == `FBWM_CMD_BUF_CLEAR) ? cmd_data2 : clr_colour[95:64];
  wire [31:0] src3 = (cmd_code == `FBWM_CMD_BUF_CLEAR) ? cmd_data3 : clr_colour[127:96];

  fbwm_clamp u_c0 (.signed_range(cmd_snorm), .din(src0), .dout(cc0)); // (R18)
  fbwm_clamp u_c1 (.signed_range(cmd_snorm), .din(src1), .dout(cc1));
  fbwm_clamp u_c2 (.signed_range(cmd_snorm), .din(src2), .dout(cc2));
  fbwm_clamp u_c3 (.signed_range(cmd_snorm), .din(src3), .dout(cc3));
  fbwm_clamp u_cd (.signed_range(1'b0), .din(cmd_data0), .dout(dclamp)); // (R14)

  // ------------------------------------------------------------
  // Command decode for errors
  // ------------------------------------------------------------
  // Mask and value commands other than the indexed mask define no error and always land
  reg [1:0] next_err;
  always @*
  begin
    next_err = `FBWM_ERR_NONE;
    if (is_cmd)
    begin
      case (cmd_code)
        `FBWM_CMD_IDX_MASK:
          if (!idx_ok)
            next_err = `FBWM_ERR_VALUE; // (R4)
        `FBWM_CMD_CLEAR:
          if (cmd_index[31:3] != 29'h0)
            next_err = `FBWM_ERR_VALUE; // (R13)
        `FBWM_CMD_BUF_CLEAR:
          if (cmd_arg == `FBWM_TGT_DEPTH_STEN)
            next_err = `FBWM_ERR_ENUM; // (R21)
          else if (cmd_arg == `FBWM_TGT_COLOUR)
          begin
            if (cmd_index[31] || !idx_ok)
              next_err = `FBWM_ERR_VALUE; // (R20)
          end
          else if (cmd_index != 32'h0)
            next_err = `FBWM_ERR_VALUE; // (R20)
        `FBWM_CMD_DS_CLEAR:
          if (cmd_arg != `FBWM_TGT_DEPTH_STEN)
            next_err = `FBWM_ERR_ENUM; // (R21)
          else if (cmd_index != 32'h0)
            next_err = `FBWM_ERR_VALUE; // (R20)
        default:
          next_err = `FBWM_ERR_NONE;
      endcase
    end
  end

  wire ok = (next_err == `FBWM_ERR_NONE);

  // ------------------------------------------------------------
  // Mask and clear value registers
  // ------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < NBUF; g = g + 1)
    begin : g_buf
      always @(posedge sys_clk)
      begin
        if (!rstn)
        begin
          cmask[g]   <= `FBWM_RST_CMASK; // (R5)
          // Only selector 0 names a buffer (buffer 0) after reset
          sel_map[g] <= (g == 0) ? {{(NBUF-1){1'b0}}, 1'b1} : {NBUF{1'b0}};
        end
        else if (is_cmd && ok)
        begin
          if (cmd_code == `FBWM_CMD_ALL_MASK)
            cmask[g] <= cmd_rgba; // (R3)
          else if (cmd_code == `FBWM_CMD_IDX_MASK && idx == g)
            cmask[g] <= cmd_rgba; // (R3)
          else if (cmd_code == `FBWM_CMD_SET_SEL && idx == g)
            sel_map[g] <= cmd_data0[NBUF-1:0];
        end
      end
    end
  endgenerate

  always @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      depth_we    <= 1'b1; // (R5)
      sten_front  <= {SBITS{1'b1}}; // (R11)
      sten_back   <= {SBITS{1'b1}}; // (R11)
      clr_colour  <= 128'h0; // (R19)
      clr_depth   <= `FBWM_RST_DEPTH_CLR; // (R19)
      clr_stencil <= {SBITS{1'b0}}; // (R19)
    end
    else if (is_cmd)
    begin
      case (cmd_code)
        `FBWM_CMD_DEPTH_EN:
          depth_we <= (cmd_data0 != 32'h0); // (R6)
        `FBWM_CMD_STEN_MASK:
        begin
          sten_front <= cmd_data0[SBITS-1:0]; // (R9) (R7)
          sten_back  <= cmd_data0[SBITS-1:0];
        end
        `FBWM_CMD_FACE_MASK:
        begin
          if (cmd_arg[0])
            sten_front <= cmd_data0[SBITS-1:0]; // (R9)
          if (cmd_arg[1])
            sten_back <= cmd_data0[SBITS-1:0]; // (R9)
        end
        `FBWM_CMD_SET_COLOUR:
          clr_colour <= {cmd_data3, cmd_data2, cmd_data1, cmd_data0};
        `FBWM_CMD_SET_DEPTH:
          clr_depth <= dclamp; // (R14)
        `FBWM_CMD_SET_STENCIL:
          clr_stencil <= cmd_data0[SBITS-1:0]; // (R15)
        default:
          clr_stencil <= clr_stencil;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Colour write enables per physical buffer
  // ------------------------------------------------------------
  // Each selector spreads its mask over every present buffer it names; a selector
  // of none names no buffer and therefore enables nothing.
  reg [4*NBUF-1:0] frag_cen;
  reg [4*NBUF-1:0] clr_cen;
  reg [NBUF-1:0]   sel_union;
  integer s;
  integer b;
  always @*
  begin
    frag_cen  = {4*NBUF{1'b0}};
    clr_cen   = {4*NBUF{1'b0}};
    sel_union = {NBUF{1'b0}};
    for (s = 0; s < NBUF; s = s + 1)
    begin
      for (b = 0; b < NBUF; b = b + 1)
      begin
        if (sel_map[s][b] && colour_present[b]) // (R2) (R23) (R17)
        begin
          if (frag_colour_req[s])
            frag_cen[4*b +: 4] = frag_cen[4*b +: 4] | cmask[s]; // (R1)
          if (cmd_code == `FBWM_CMD_CLEAR || s == idx)
            clr_cen[4*b +: 4] = clr_cen[4*b +: 4] | cmask[s]; // (R1)
          sel_union[b] = sel_union[b] | frag_colour_req[s];
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Write issue
  // ------------------------------------------------------------
  // Clears bypass every fragment test; ownership, scissor and dither are
  // applied downstream on wr_is_clear writes.
  wire do_clear  = is_cmd && ok && (cmd_code == `FBWM_CMD_CLEAR); // (R16)
  wire do_bclear = is_cmd && ok && (cmd_code == `FBWM_CMD_BUF_CLEAR);
  wire do_ds     = is_cmd && ok && (cmd_code == `FBWM_CMD_DS_CLEAR); // (R22)
  wire clr_c     = (do_clear && cmd_index[`FBWM_CLR_COLOUR])
                 || (do_bclear && cmd_arg == `FBWM_TGT_COLOUR);
  wire clr_d     = (do_clear && cmd_index[`FBWM_CLR_DEPTH])
                 || (do_bclear && cmd_arg == `FBWM_TGT_DEPTH) || do_ds;
  wire clr_s     = (do_clear && cmd_index[`FBWM_CLR_STENCIL])
                 || (do_bclear && cmd_arg == `FBWM_TGT_STENCIL) || do_ds;
  wire [31:0]      bdepth  = (do_clear) ? clr_depth : dclamp; // (R14)
  wire [SBITS-1:0] bsten   = do_clear ? clr_stencil
                           : (do_ds ? cmd_data1[SBITS-1:0] : cmd_data0[SBITS-1:0]); // (R15)
  wire             any_clr = clr_c || clr_d || clr_s;

  always @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      wr_valid      <= 1'b0;
      wr_sample     <= 1'b0;
      wr_is_clear   <= 1'b0;
      wr_colour_en  <= {4*NBUF{1'b0}};
      wr_depth_en   <= 1'b0;
      wr_stencil_en <= {SBITS{1'b0}};
      wr_colour     <= 128'h0;
      wr_depth      <= 32'h0;
      wr_stencil    <= {SBITS{1'b0}};
      resolve_valid <= 1'b0;
      resolve_en    <= {NBUF{1'b0}};
      err_valid     <= 1'b0;
      err_code      <= `FBWM_ERR_NONE;
    end
    else
    begin
      err_valid <= is_cmd && !ok;
      err_code  <= next_err;
      wr_sample <= multisample; // (R12)
      if (any_clr)
      begin
        wr_valid      <= 1'b1;
        wr_is_clear   <= 1'b1;
        wr_colour_en  <= clr_c ? clr_cen : {4*NBUF{1'b0}};
        wr_depth_en   <= clr_d && depth_we && depth_present; // (R6) (R17)
        wr_stencil_en <= (clr_s && stencil_present) ? sten_front : {SBITS{1'b0}}; // (R10)
        wr_colour     <= {cc3, cc2, cc1, cc0}; // (R18)
        wr_depth      <= bdepth;
        wr_stencil    <= bsten;
        resolve_valid <= 1'b0;
        resolve_en    <= {NBUF{1'b0}};
      end
      else
      begin
        wr_valid      <= frag_valid;
        wr_is_clear   <= 1'b0;
        wr_colour_en  <= frag_cen;
        wr_depth_en   <= frag_depth_req && depth_we && depth_present; // (R6)
        wr_stencil_en <= (frag_stencil_req && stencil_present)
                         ? (frag_back ? sten_back : sten_front) : {SBITS{1'b0}}; // (R8) (R7)
        wr_depth      <= frag_depth;
        wr_stencil    <= frag_stencil;
        // Resolve replaces selected buffers regardless of colour enables
        resolve_valid <= frag_valid && multisample; // (R12)
        resolve_en    <= sel_union;
      end
    end
  end

  // ------------------------------------------------------------
  // Register read port
  // ------------------------------------------------------------
  // Registers are read-only; state is loaded through commands, so the
  // write strobe and write data of this port are left unused on purpose.
  wire [IDXW-1:0] ridx = reg_addr[IDXW-1:0];
  always @(posedge sys_clk)
  begin
    if (!rstn)
      reg_rdata <= 32'h0;
    else if (reg_rd)
    begin
      case (reg_addr[7:4])
        `FBWM_REG_CMASK:       reg_rdata <= {28'h0, cmask[ridx]};
        `FBWM_REG_DEPTH_EN:    reg_rdata <= {31'h0, depth_we};
        `FBWM_REG_STEN_FRONT:  reg_rdata <= {{(32-SBITS){1'b0}}, sten_front};
        `FBWM_REG_STEN_BACK:   reg_rdata <= {{(32-SBITS){1'b0}}, sten_back};
        `FBWM_REG_CLR_DEPTH:   reg_rdata <= clr_depth;
        `FBWM_REG_CLR_STENCIL: reg_rdata <= {{(32-SBITS){1'b0}}, clr_stencil};
        `FBWM_REG_CLR_COLOUR:  reg_rdata <= clr_colour[32*reg_addr[1:0] +: 32];
        default: reg_rdata <= 32'h0;
      endcase
    end
    else
      reg_rdata <= 32'h0;
  end

endmodule

// ==== verification/fbwm_props.sv ====
/*
  Port checker for the write-mask and clear stage.
  Assumes a bind onto fbwm_top with one clock and a synchronous low reset.
*/
`timescale 1ns/10ps
`include "fbwm_defs.vh"

module fbwm_props
#(
  parameter NBUF  = 4,
  parameter SBITS = 8,
  parameter IDXW  = 2
)
(
  input wire        sys_clk,
  input wire        rstn,
  input wire        cmd_valid,
  input wire [3:0]  cmd_code,
  input wire [31:0] cmd_index,
  input wire [1:0]  cmd_arg,
  input wire        depth_present,
  input wire        frag_valid,
  input wire        wr_valid,
  input wire        wr_is_clear,
  input wire        wr_depth_en,
  input wire [31:0] wr_depth,
  input wire        err_valid,
  input wire [1:0]  err_code
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);

  // ----------------------------------------
  // Command and fragment answers
  // ----------------------------------------
  AST_IDX_RANGE:
  assert property (cmd_valid && cmd_code == `FBWM_CMD_IDX_MASK && cmd_index >= NBUF
    |=> err_valid && err_code == `FBWM_ERR_VALUE) else $error("index range not flagged");
  AST_CLR_BITS:
  assert property (cmd_valid && cmd_code == `FBWM_CMD_CLEAR && cmd_index[31:3] != 0
    |=> err_valid && err_code == `FBWM_ERR_VALUE && !wr_valid) else $error("bad clear bits");
  AST_CLR_RUN:
  assert property (cmd_valid && cmd_code == `FBWM_CMD_CLEAR && cmd_index == 7
    |=> wr_valid && wr_is_clear && !err_valid) else $error("clear not issued");
  AST_DS_TGT:
  assert property (cmd_valid && cmd_code == `FBWM_CMD_DS_CLEAR && cmd_arg != `FBWM_TGT_DEPTH_STEN
    |=> err_valid && err_code == `FBWM_ERR_ENUM) else $error("combined target not flagged");
  AST_BUF_TGT:
  assert property (cmd_valid && cmd_code == `FBWM_CMD_BUF_CLEAR && cmd_arg == `FBWM_TGT_DEPTH_STEN
    |=> err_valid && err_code == `FBWM_ERR_ENUM) else $error("buffer target not flagged");
  AST_ZERO_IDX:
  assert property (cmd_valid && cmd_index != 0 && ((cmd_code == `FBWM_CMD_BUF_CLEAR
    && (cmd_arg == `FBWM_TGT_DEPTH || cmd_arg == `FBWM_TGT_STENCIL))
    || (cmd_code == `FBWM_CMD_DS_CLEAR && cmd_arg == `FBWM_TGT_DEPTH_STEN))
    |=> err_valid && err_code == `FBWM_ERR_VALUE) else $error("non-zero index not flagged");
  AST_NO_DEPTH:
  assert property (cmd_valid && cmd_code == `FBWM_CMD_CLEAR && cmd_index == 2 && !depth_present
    |=> !wr_depth_en && !err_valid) else $error("absent depth touched");
  AST_DEPTH_RANGE:
  assert property (wr_valid && wr_is_clear && wr_depth_en
    |-> !wr_depth[31] && wr_depth <= `FBWM_FP_ONE) else $error("clear depth out of range");
  AST_FRAG_PASS:
  assert property (frag_valid && !cmd_valid |=> wr_valid && !wr_is_clear)
    else $error("fragment write missing");

  cover property (err_valid && err_code == `FBWM_ERR_ENUM);
  cover property (wr_valid && wr_is_clear && wr_depth_en);
  cover property (wr_valid && !wr_is_clear);
endmodule

// ==== verification/fbwm_store_model.sv ====
/*
  Storage model: one pixel of depth and stencil, updated under the write enables.
  Assumes the stage's registered write outputs on the same clock.
*/
`timescale 1ns/10ps

module fbwm_store_model
#(
  parameter SBITS = 8
)
(
  input  wire              sys_clk,
  input  wire              rstn,
  input  wire              wr_valid,
  input  wire              wr_depth_en,
  input  wire [SBITS-1:0]  wr_stencil_en,
  input  wire [31:0]       wr_depth,
  input  wire [SBITS-1:0]  wr_stencil,
  output logic [SBITS-1:0] stencil_cell,
  output logic [31:0]      depth_cell
);
  always @(posedge sys_clk)
  begin
    if (!rstn)
    begin
      stencil_cell <= {SBITS{1'b0}};
      depth_cell   <= 32'h0;
    end
    else if (wr_valid)
    begin
      // Enabled bits take the new value, the others keep theirs
      stencil_cell <= (stencil_cell & ~wr_stencil_en) | (wr_stencil & wr_stencil_en);
      if (wr_depth_en)
        depth_cell <= wr_depth;
    end
  end
endmodule

// ==== verification/testbench.sv ====
/*
  Testbench for fbwm_top: command table with register readback, then clears,
  fragments and reset by hand. Assumes the checker and storage model files.
*/
`timescale 1ns/10ps
`include "fbwm_defs.vh"

module testbench;
  typedef struct {
    logic [3:0]  code;
    logic [31:0] idx;
    logic [1:0]  arg;
    logic [31:0] d0;
    logic [7:0]  addr;
    logic [31:0] exp;
    logic [1:0]  err;
  } fbwm_row_t;

  logic         sys_clk, rstn, cmd_valid, cmd_snorm, depth_present, stencil_present;
  logic         multisample, frag_valid, frag_back, frag_depth_req, frag_stencil_req;
  logic         reg_wr, reg_rd, wr_valid, wr_sample, wr_is_clear, wr_depth_en;
  logic         resolve_valid, err_valid;
  logic [1:0]   cmd_arg, err_code;
  logic [3:0]   cmd_code, cmd_rgba, colour_present, frag_colour_req, resolve_en;
  logic [7:0]   reg_addr, frag_stencil, wr_stencil_en, wr_stencil, cell_st;
  logic [15:0]  wr_colour_en;
  logic [31:0]  cmd_index, cmd_data0, cmd_data1, frag_depth, reg_wdata, wr_depth;
  logic [31:0]  reg_rdata, cell_dp, rd_val;
  logic [127:0] wr_colour;
  int           n_fail, comparisons;
  fbwm_row_t    rows [0:17];
  logic [7:0]   ra [0:8] = '{8'h00, 8'h03, 8'h10, 8'h20, 8'h30, 8'h40, 8'h50, 8'h60, 8'hf0};
  logic [31:0]  rv [0:8] = '{32'hf, 32'hf, 32'h1, 32'hff, 32'hff, 32'h3f800000, 0, 0, 0};

  fbwm_top #(.NBUF(4), .SBITS(8), .IDXW(2)) u_fbwm_top
    (.*, .cmd_data2(cmd_data0), .cmd_data3(cmd_data0));
  fbwm_store_model #(.SBITS(8)) u_fbwm_store_model (.sys_clk(sys_clk), .rstn(rstn),
    .wr_valid(wr_valid), .wr_depth_en(wr_depth_en), .wr_stencil_en(wr_stencil_en),
    .wr_depth(wr_depth), .wr_stencil(wr_stencil), .stencil_cell(cell_st), .depth_cell(cell_dp));

  always #4 sys_clk = ~sys_clk;

  // ----------------------------------------
  // Drivers and comparison
  // ----------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cmd(input logic [3:0] c, input logic [31:0] x, input logic [1:0] a,
                     input logic [31:0] d0, input logic [31:0] d1);
    @(posedge sys_clk);
    cmd_valid <= 1'b1;
    cmd_code  <= c;
    cmd_index <= x;
    cmd_arg   <= a;
    cmd_rgba  <= d0[3:0];
    cmd_data0 <= d0;
    cmd_data1 <= d1;
    @(posedge sys_clk);
    cmd_valid <= 1'b0;
    #1;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask

  task automatic frag(input logic back, input logic [3:0] creq);
    @(posedge sys_clk);
    frag_valid      <= 1'b1;
    frag_back       <= back;
    frag_colour_req <= creq;
    @(posedge sys_clk);
    frag_valid <= 1'b0;
    #1;
  endtask

  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial
  begin
    {sys_clk, rstn, cmd_valid, cmd_snorm, multisample, frag_valid, frag_back, reg_wr, reg_rd} = '0;
    {cmd_code, cmd_index, cmd_arg, cmd_rgba, cmd_data0, cmd_data1, reg_addr, reg_wdata} = '0;
    {frag_colour_req, frag_stencil} = '0;
    {depth_present, stencil_present, frag_depth_req, frag_stencil_req} = 4'hf;
    colour_present = 4'hf;
    frag_depth = 32'h3e800000;
    n_fail = 0;
    comparisons = 0;
    rows = '{
      '{`FBWM_CMD_ALL_MASK, 0, 0, 32'h5, 8'h03, 32'h5, `FBWM_ERR_NONE},
      '{`FBWM_CMD_IDX_MASK, 2, 0, 32'ha, 8'h02, 32'ha, `FBWM_ERR_NONE},
      '{`FBWM_CMD_IDX_MASK, 4, 0, 32'h0, 8'h02, 32'ha, `FBWM_ERR_VALUE},
      '{`FBWM_CMD_DEPTH_EN, 0, 0, 32'h0, 8'h10, 32'h0, `FBWM_ERR_NONE},
      '{`FBWM_CMD_DEPTH_EN, 2, 0, 32'h2, 8'h10, 32'h1, `FBWM_ERR_NONE},
      '{`FBWM_CMD_STEN_MASK, 32'h13c, 0, 32'h13c, 8'h30, 32'h3c, `FBWM_ERR_NONE},
      '{`FBWM_CMD_FACE_MASK, 32'hf0, `FBWM_FACE_FRONT, 32'hf0, 8'h20, 32'hf0, `FBWM_ERR_NONE},
      '{`FBWM_CMD_FACE_MASK, 32'h0f, `FBWM_FACE_BACK, 32'h0f, 8'h30, 32'h0f, `FBWM_ERR_NONE},
      '{`FBWM_CMD_SET_DEPTH, 0, 0, 32'h40000000, 8'h40, 32'h3f800000, `FBWM_ERR_NONE},
      '{`FBWM_CMD_SET_DEPTH, 0, 0, 32'hbf800000, 8'h40, 32'h0, `FBWM_ERR_NONE},
      '{`FBWM_CMD_SET_DEPTH, 0, 0, 32'h3f000000, 8'h40, 32'h3f000000, `FBWM_ERR_NONE},
      '{`FBWM_CMD_SET_STENCIL, 0, 0, 32'h1a5, 8'h50, 32'ha5, `FBWM_ERR_NONE},
      '{`FBWM_CMD_SET_COLOUR, 0, 0, 32'h40000000, 8'h63, 32'h40000000, `FBWM_ERR_NONE},
      '{`FBWM_CMD_CLEAR, 8, 0, 32'h0, 8'h50, 32'ha5, `FBWM_ERR_VALUE},
      '{`FBWM_CMD_BUF_CLEAR, 0, `FBWM_TGT_DEPTH_STEN, 0, 8'h20, 32'hf0, `FBWM_ERR_ENUM},
      '{`FBWM_CMD_DS_CLEAR, 0, `FBWM_TGT_COLOUR, 0, 8'h20, 32'hf0, `FBWM_ERR_ENUM},
      '{`FBWM_CMD_BUF_CLEAR, 4, `FBWM_TGT_COLOUR, 0, 8'h20, 32'hf0, `FBWM_ERR_VALUE},
      '{`FBWM_CMD_BUF_CLEAR, 1, `FBWM_TGT_STENCIL, 0, 8'h20, 32'hf0, `FBWM_ERR_VALUE}};
    repeat (8) @(posedge sys_clk);
    rstn <= 1'b1;
    foreach (rows[i])
    begin
      cmd(rows[i].code, rows[i].idx, rows[i].arg, rows[i].d0, 32'h0);
      check({30'h0, err_valid ? err_code : 2'h0}, {30'h0, rows[i].err});
      rd(rows[i].addr, rd_val);
      check(rd_val, rows[i].exp);
    end
    cmd(`FBWM_CMD_CLEAR, 7, 0, 0, 0);
    check({wr_valid, wr_is_clear, wr_depth_en}, 3'h7);
    check({wr_stencil_en, wr_stencil, wr_colour_en[3:0]}, 20'hf0a55);
    check(wr_depth, 32'h3f000000);
    check(32'(wr_colour == {{2{32'h3f800000}}, 32'h0, 32'h3f800000}), 1);
    @(posedge sys_clk);
    #1;
    check(32'(cell_st), 32'ha0);
    cmd(`FBWM_CMD_DS_CLEAR, 0, `FBWM_TGT_DEPTH_STEN, 32'h40000000, 32'h1ff);
    check({wr_depth_en, wr_stencil_en, wr_stencil}, 17'h1f0ff);
    @(posedge sys_clk);
    depth_present <= 1'b0;
    #1;
    check(cell_dp, 32'h3f800000);
    check(32'(cell_st), 32'hf0);
    cmd(`FBWM_CMD_CLEAR, 2, 0, 0, 0);
    check({err_valid, wr_depth_en}, 2'h0);
    depth_present <= 1'b1;
    cmd(`FBWM_CMD_DEPTH_EN, 0, 0, 0, 0);
    frag(1'b1, 4'h1);
    check({wr_valid, wr_depth_en, wr_stencil_en, wr_colour_en[3:0]}, 14'h20f5);
    frag(1'b0, 4'h2);
    check({wr_stencil_en, wr_colour_en}, 24'hf00000);
    cmd(`FBWM_CMD_SET_SEL, 1, 0, 32'h6, 0);
    multisample <= 1'b1;
    cmd_snorm   <= 1'b1;
    frag(1'b0, 4'h2);
    check({wr_sample, resolve_valid, resolve_en, wr_colour_en}, 22'h360550);
    cmd(`FBWM_CMD_BUF_CLEAR, 1, `FBWM_TGT_COLOUR, 32'hc0000000, 32'hbf000000);
    check({wr_sample, wr_is_clear, wr_colour_en}, 18'h30550);
    check(wr_colour[31:0], 32'hbf800000);
    check(wr_colour[63:32], 32'hbf000000);
    cmd(`FBWM_CMD_CLEAR, 0, 0, 0, 0);
    check({wr_valid, err_valid}, 2'h0);
    @(posedge sys_clk);
    rstn   <= 1'b0;
    reg_wr <= 1'b1;
    repeat (8) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    #1;
    check({wr_valid, err_valid}, 2'h0);
    foreach (ra[k])
    begin
      rd(ra[k], rd_val);
      check(rd_val, rv[k]);
    end
    conclude();
  end

  initial
  begin
    repeat (20000) @(posedge sys_clk);
    n_fail++;
    conclude();
  end
endmodule

bind fbwm_top fbwm_props #(.NBUF(NBUF), .SBITS(SBITS), .IDXW(IDXW)) u_fbwm_props
  (.sys_clk(sys_clk), .rstn(rstn), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
   .cmd_index(cmd_index), .cmd_arg(cmd_arg), .depth_present(depth_present),
   .frag_valid(frag_valid), .wr_valid(wr_valid), .wr_is_clear(wr_is_clear),
   .wr_depth_en(wr_depth_en), .wr_depth(wr_depth), .err_valid(err_valid), .err_code(err_code));
